// File: bench/rcmr_top_bench.sv
// Register-level testbench for the reset cause and remap block
`timescale 1ns/1ps
module rcmr_top_bench;
	import rcmr_pkg::*;
	logic clk;
	logic rst_n;
	rcmr_axi_req_t req;
	rcmr_axi_rsp_t rsp;
	logic ext_n, wdt, boot, fsram, sys_n, gpio_n, dac_n, krun, urun, dl, irq;
	logic [31:0] faddr;
	logic [31:0] rdat;
	logic [1:0] rrsp;
	logic [1:0] brsp;
	int bad_count;
	int n_checks;
	rcmr_top i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .AXI_REQ_I(req),
		.AXI_RSP_O(rsp), .EXT_RST_N_I(ext_n), .WDT_EXPIRE_I(wdt),
		.BOOT_SELECT_PIN_I(boot), .FETCH_ADDR_I(faddr),
		.FETCH_SRAM_O(fsram), .SYS_RST_N_O(sys_n), .GPIO_RST_N_O(gpio_n),
		.DAC_RST_N_O(dac_n), .KERNEL_RUN_O(krun), .USER_RUN_O(urun),
		.DOWNLOAD_MODE_O(dl), .IRQ_O(irq));
	always #5 clk = ~clk;
	// ****************************************************
	// Bus and compare tasks
	// ****************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask : chk
	task chk_pin(input logic got, input logic exp, input string s);
		chk({31'h00000000, got}, {31'h00000000, exp}, s);
	endtask : chk_pin
	task chk_rsp(input logic [1:0] got, input logic [1:0] exp, input string s);
		chk({30'h0, got}, {30'h0, exp}, s);
	endtask : chk_rsp
	// Readies are registered, so the level seen at the falling edge holds
	// at the next rising edge where the transfer is taken
	task wr(input logic [31:0] a, input logic [7:0] d);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk);
		req.awaddr <= a;
		req.wdata <= {24'h000000, d};
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(negedge clk);
			pa = pa & ~rsp.awready;
			pw = pw & ~rsp.wready;
			@(posedge clk);
			req.awvalid <= pa;
			req.wvalid <= pw;
		end
		while (pa || pw);
		do
			@(negedge clk);
		while (rsp.bvalid !== 1'b1);
		brsp = rsp.bresp;
		@(posedge clk);
		req.bready <= 1'b0;
	endtask : wr
	task rd(input logic [31:0] a);
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
			@(negedge clk);
		while (rsp.arready !== 1'b1);
		@(posedge clk);
		req.arvalid <= 1'b0;
		do
			@(negedge clk);
		while (rsp.rvalid !== 1'b1);
		rdat = rsp.rdata;
		rrsp = rsp.rresp;
		@(posedge clk);
		req.rready <= 1'b0;
	endtask : rd
	task rdchk(input logic [31:0] a, input logic [7:0] e);
		rd(a);
		chk(rdat, {24'h000000, e}, "read data");
		chk_rsp(rrsp, RCMR_RESP_OKAY, "resp");
	endtask : rdchk
	task key(input logic [7:0] v);
		wr(RCMR_KEY_FIRST_ADDR, RCMR_KEY_FIRST);
		wr(RCMR_CFG_ADDR, v);
		wr(RCMR_KEY_SECOND_ADDR, RCMR_KEY_SECOND);
	endtask : key
	task fchk(input logic [31:0] a, input logic e);
		@(posedge clk);
		faddr <= a;
		repeat (2) @(negedge clk);
		chk_pin(fsram, e, "fetch select");
	endtask : fchk
	task wait_user;
		do
			@(negedge clk);
		while (urun !== 1'b1);
	endtask : wait_user
	task summarize;
		$display("Checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// Five boot sequences of about 210 cycles plus bus traffic fit well
	initial
	begin
		#300000;
		bad_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		summarize();
	end
	// ****************************************************
	// Tests
	// ****************************************************
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		req = '0;
		ext_n = 1'b1;
		wdt = 1'b0;
		boot = 1'b1;
		faddr = 32'h00000000;
		bad_count = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		wait_user();
		rdchk(RCMR_FLAGS_ADDR, 8'h01);
		rdchk(RCMR_CFG_ADDR, 8'h05);
		rdchk(RCMR_MIRROR_SEL_ADDR, 8'h00);
		rdchk(RCMR_CLEAR_ADDR, 8'h00);
		rd(32'hFFFF0300);
		chk_rsp(rrsp, RCMR_RESP_DECERR, "unmapped read");
		wr(32'hFFFF0300, 8'h01);
		chk_rsp(brsp, RCMR_RESP_DECERR, "unmapped write");
		$display("test reset values done");
		wr(RCMR_MIRROR_SEL_ADDR, 8'hFF);
		chk_rsp(brsp, RCMR_RESP_OKAY, "write resp");
		rdchk(RCMR_MIRROR_SEL_ADDR, 8'h01);
		fchk(32'h00000000, 1'b1);
		fchk(32'h00000020, 1'b1);
		fchk(32'h00000024, 1'b0);
		wr(RCMR_MIRROR_SEL_ADDR, 8'h00);
		fchk(32'h00000000, 1'b0);
		$display("test mirror done");
		key(8'h01);
		rdchk(RCMR_CFG_ADDR, 8'h01);
		wr(RCMR_CFG_ADDR, 8'h04);
		rdchk(RCMR_CFG_ADDR, 8'h01);
		wr(RCMR_KEY_FIRST_ADDR, RCMR_KEY_FIRST);
		wr(RCMR_MIRROR_SEL_ADDR, 8'h00);
		wr(RCMR_CFG_ADDR, 8'h04);
		wr(RCMR_KEY_SECOND_ADDR, RCMR_KEY_SECOND);
		rdchk(RCMR_CFG_ADDR, 8'h01);
		rdchk(RCMR_IRQ_STAT_ADDR, 8'h08);
		wr(RCMR_IRQ_MASK_ADDR, 8'h08);
		@(negedge clk);
		chk_pin(irq, 1'b1, "irq raised");
		wr(RCMR_IRQ_STAT_ADDR, 8'h08);
		repeat (2) @(negedge clk);
		chk_pin(irq, 1'b0, "irq cleared");
		$display("test key sequence done");
		wr(RCMR_MIRROR_SEL_ADDR, 8'h01);
		wr(RCMR_IRQ_MASK_ADDR, 8'h02);
		@(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		repeat (2) @(negedge clk);
		chk_pin(sys_n, 1'b0, "wdt hold");
		chk_pin(gpio_n, 1'b1, "gpio kept");
		chk_pin(dac_n, 1'b0, "dac reset");
		chk_pin(irq, 1'b1, "wdt irq");
		wait_user();
		rdchk(RCMR_FLAGS_ADDR, 8'h03);
		rdchk(RCMR_MIRROR_SEL_ADDR, 8'h00);
		wr(RCMR_CLEAR_ADDR, 8'h02);
		rdchk(RCMR_FLAGS_ADDR, 8'h01);
		wr(RCMR_CLEAR_ADDR, RCMR_CLEAR_ALL);
		rdchk(RCMR_FLAGS_ADDR, 8'h00);
		wr(RCMR_IRQ_STAT_ADDR, 8'h0F);
		$display("test watchdog done");
		key(8'h04);
		wr(RCMR_CTRL_ADDR, 8'h01);
		@(negedge clk);
		chk_pin(sys_n, 1'b0, "sw hold");
		chk_pin(gpio_n, 1'b0, "gpio reset");
		chk_pin(dac_n, 1'b1, "dac kept");
		wait_user();
		rdchk(RCMR_FLAGS_ADDR, 8'h04);
		wr(RCMR_CLEAR_ADDR, RCMR_CLEAR_ALL);
		wr(RCMR_IRQ_STAT_ADDR, 8'h0F);
		$display("test software reset done");
		wr(RCMR_MIRROR_SEL_ADDR, 8'h01);
		@(posedge clk);
		ext_n <= 1'b0;
		repeat (4) @(posedge clk);
		ext_n <= 1'b1;
		wait_user();
		rdchk(RCMR_FLAGS_ADDR, 8'h00);
		rdchk(RCMR_MIRROR_SEL_ADDR, 8'h00);
		rdchk(RCMR_IRQ_STAT_ADDR, 8'h01);
		$display("test external reset done");
		@(posedge clk);
		boot <= 1'b0;
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		do
			@(negedge clk);
		while (dl !== 1'b1);
		chk_pin(urun, 1'b0, "no user run");
		chk_pin(krun, 1'b0, "kernel over");
		rdchk(RCMR_FLAGS_ADDR, 8'h02);
		$display("test download boot done");
		summarize();
	end
endmodule : rcmr_top_bench

// File: bench/rcmr_top_sva.sv
// Port-level assertions for the reset cause and remap block
`timescale 1ns/1ps
module rcmr_top_sva
(
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic WDT_EXPIRE_I,
	input wire logic [31:0] FETCH_ADDR_I,
	input wire logic FETCH_SRAM_O,
	input wire logic SYS_RST_N_O,
	input wire logic GPIO_RST_N_O,
	input wire logic DAC_RST_N_O,
	input wire logic KERNEL_RUN_O,
	input wire logic USER_RUN_O,
	input wire logic DOWNLOAD_MODE_O,
	input wire logic IRQ_O
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	// ****************************************************
	// Assertions
	// ****************************************************
	a_wdt_starts_hold: assert property (WDT_EXPIRE_I |=> !SYS_RST_N_O)
		else $error("watchdog pulse did not start the hold");
	a_hold_lasts: assert property (
		$fell(SYS_RST_N_O) |-> !SYS_RST_N_O[*8])
		else $error("system hold ended too early");
	a_fetch_window: assert property (
		FETCH_SRAM_O |-> $past(FETCH_ADDR_I) <= 32'h00000020)
		else $error("sram fetch outside the vector area");
	// One cycle of slack: the mirror bit drops at the edge the hold begins
	a_hold_flash_low: assert property (
		!SYS_RST_N_O && !$past(SYS_RST_N_O) |-> !FETCH_SRAM_O)
		else $error("sram still mirrored during reset");
	a_one_phase: assert property (
		$onehot0({KERNEL_RUN_O, USER_RUN_O, DOWNLOAD_MODE_O}))
		else $error("more than one boot phase active");
	a_kernel_first: assert property (
		$rose(USER_RUN_O) |-> $past(KERNEL_RUN_O))
		else $error("user code started without kernel phase");
	a_kernel_span: assert property (
		$rose(KERNEL_RUN_O) |-> KERNEL_RUN_O[*8])
		else $error("kernel phase cut short");
	a_gpio_in_hold: assert property (!GPIO_RST_N_O |-> !SYS_RST_N_O)
		else $error("gpio reset outside system hold");
	a_dac_in_hold: assert property (!DAC_RST_N_O |-> !SYS_RST_N_O)
		else $error("dac reset outside system hold");
	c_wdt: cover property (WDT_EXPIRE_I);
	c_user: cover property ($rose(USER_RUN_O));
	c_irq: cover property ($rose(IRQ_O));
endmodule : rcmr_top_sva

bind rcmr_top rcmr_top_sva i_sva (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
	.WDT_EXPIRE_I(WDT_EXPIRE_I), .FETCH_ADDR_I(FETCH_ADDR_I),
	.FETCH_SRAM_O(FETCH_SRAM_O), .SYS_RST_N_O(SYS_RST_N_O),
	.GPIO_RST_N_O(GPIO_RST_N_O), .DAC_RST_N_O(DAC_RST_N_O),
	.KERNEL_RUN_O(KERNEL_RUN_O), .USER_RUN_O(USER_RUN_O),
	.DOWNLOAD_MODE_O(DOWNLOAD_MODE_O), .IRQ_O(IRQ_O));

// File: core/rcmr_pkg.sv
// Constants, types and bus carriers of the reset cause and memory remap block
package rcmr_pkg;
	// ****************************************************
	// Register byte addresses
	// ****************************************************
	localparam logic [31:0] RCMR_MIRROR_SEL_ADDR = 32'hFFFF0220;
	localparam logic [31:0] RCMR_FLAGS_ADDR = 32'hFFFF0230;
	localparam logic [31:0] RCMR_CLEAR_ADDR = 32'hFFFF0234;
	localparam logic [31:0] RCMR_KEY_FIRST_ADDR = 32'hFFFF0248;
	localparam logic [31:0] RCMR_CFG_ADDR = 32'hFFFF024C;
	localparam logic [31:0] RCMR_KEY_SECOND_ADDR = 32'hFFFF0250;
	localparam logic [31:0] RCMR_CTRL_ADDR = 32'hFFFF0260;
	localparam logic [31:0] RCMR_IRQ_STAT_ADDR = 32'hFFFF0264;
	localparam logic [31:0] RCMR_IRQ_MASK_ADDR = 32'hFFFF0268;
	// ****************************************************
	// Field positions and reset values
	// ****************************************************
	localparam int RCMR_MIRROR_BIT = 0;
	localparam int RCMR_FLAG_POR = 0;
	localparam int RCMR_FLAG_WDT = 1;
	localparam int RCMR_FLAG_SW = 2;
	localparam int RCMR_CFG_GPIO = 0;
	localparam int RCMR_CFG_DAC = 2;
	localparam int RCMR_CTRL_SWRST = 0;
	localparam int RCMR_IRQ_EXT = 0;
	localparam int RCMR_IRQ_WDT = 1;
	localparam int RCMR_IRQ_SW = 2;
	localparam int RCMR_IRQ_KEYERR = 3;
	localparam int RCMR_IRQ_W = 4;
	localparam logic [7:0] RCMR_MIRROR_RST = 8'h00;
	localparam logic [7:0] RCMR_FLAGS_RST = 8'h01;
	localparam logic [7:0] RCMR_FLAGS_MASK = 8'h07;
	localparam logic [7:0] RCMR_CFG_RST = 8'h05;
	localparam logic [7:0] RCMR_CFG_MASK = 8'h05;
	localparam logic [7:0] RCMR_KEY_FIRST = 8'h76;
	localparam logic [7:0] RCMR_KEY_SECOND = 8'hB1;
	localparam logic [7:0] RCMR_CLEAR_ALL = 8'h07;
	localparam logic [31:0] RCMR_MIRROR_BASE = 32'h00000000;
	localparam logic [31:0] RCMR_MIRROR_TOP = 32'h00000020;
	localparam logic [1:0] RCMR_RESP_OKAY = 2'h0;
	localparam logic [1:0] RCMR_RESP_DECERR = 2'h3;
	// ****************************************************
	// Timing
	// ****************************************************
	localparam int RCMR_CLK_PERIOD_NS = 10;
	localparam int RCMR_RST_HOLD_NS = 100;
	localparam int RCMR_KERNEL_NS = 2000;
	localparam logic [15:0] RCMR_RST_HOLD_CYC = 16'((RCMR_RST_HOLD_NS
		+ RCMR_CLK_PERIOD_NS - 1) / RCMR_CLK_PERIOD_NS);
	localparam logic [15:0] RCMR_KERNEL_CYC = 16'((RCMR_KERNEL_NS
		+ RCMR_CLK_PERIOD_NS - 1) / RCMR_CLK_PERIOD_NS);
	// ****************************************************
	// Types
	// ****************************************************
	typedef enum logic [1:0]
	{
		RCMR_ST_HOLD = 2'b00,
		RCMR_ST_KERNEL = 2'b01,
		RCMR_ST_USER = 2'b10,
		RCMR_ST_DOWNLOAD = 2'b11
	} rcmr_state_t;
	typedef enum logic [1:0]
	{
		RCMR_KEY_IDLE = 2'b00,
		RCMR_KEY_ARMED = 2'b01,
		RCMR_KEY_LOADED = 2'b10
	} rcmr_key_t;
	typedef struct packed
	{
		logic [31:0] awaddr;
		logic [2:0] awprot;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic [2:0] arprot;
		logic arvalid;
		logic rready;
	} rcmr_axi_req_t;
	typedef struct packed
	{
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} rcmr_axi_rsp_t;
endpackage : rcmr_pkg

// File: core/rcmr_top.sv
// Reset cause record, retention keys, boot sequencing and low memory remap
`timescale 1ns/1ps
// ****************************************************
// Summary of operation
// ****************************************************
// Summary of operation
// - Every kind of reset clears the mirror select bit, flash sits low.
// - Mirror bit one puts SRAM at zero; clearing it restores flash.
// - The mirrored region covers the vector area from zero to 0x20.
// - After reset run the hidden kernel; boot pin high then jumps to zero.
// - Four reset sources are told apart; cause flags accumulate until cleared.
// - Power-on sets cause bit 0; flags read 0x01 after power-up.
// - Watchdog timeout sets cause bit 1, sticky until cleared.
// - Software reset sets cause bit 2, sticky until cleared.
// - All cause flags zero means the last reset was external.
// - Writing 0x07 to the clear register clears every flag written one.
// - Config bit 2 keeps DAC state through watchdog or software reset.
// - Config bit 0 keeps GPIO state through watchdog or software reset.
module rcmr_top
(
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire rcmr_pkg::rcmr_axi_req_t AXI_REQ_I,
	output rcmr_pkg::rcmr_axi_rsp_t AXI_RSP_O,
	input wire logic EXT_RST_N_I,
	input wire logic WDT_EXPIRE_I,
	input wire logic BOOT_SELECT_PIN_I,
	input wire logic [31:0] FETCH_ADDR_I,
	output logic FETCH_SRAM_O,
	output logic SYS_RST_N_O,
	output logic GPIO_RST_N_O,
	output logic DAC_RST_N_O,
	output logic KERNEL_RUN_O,
	output logic USER_RUN_O,
	output logic DOWNLOAD_MODE_O,
	output logic IRQ_O
);
	import rcmr_pkg::*;

	// ****************************************************
	// Pin synchronisers
	// ****************************************************
	logic ext_s1_r;
	logic ext_s2_r;
	logic ext_prev_r;
	logic boot_s1_r;
	logic boot_s2_r;

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			ext_s1_r <= 1'b1;
			ext_s2_r <= 1'b1;
			ext_prev_r <= 1'b1;
			boot_s1_r <= 1'b1;
			boot_s2_r <= 1'b1;
		end
		else
		begin
			ext_s1_r <= EXT_RST_N_I;
			ext_s2_r <= ext_s1_r;
			ext_prev_r <= ext_s2_r;
			boot_s1_r <= BOOT_SELECT_PIN_I;
			boot_s2_r <= boot_s1_r;
		end
	end

	// ****************************************************
	// AXI4-Lite slave
	// ****************************************************
	logic aw_got_r;
	logic w_got_r;
	logic [31:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic w_lane0_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic do_wr;
	logic aw_got_nxt;
	logic w_got_nxt;
	logic bvalid_nxt;
	logic rvalid_nxt;
	logic wr_hit;
	logic [7:0] wr_byte;
	logic [31:0] rd_word;
	logic rd_hit;

	assign do_wr = aw_got_r & w_got_r & ~bvalid_r;
	assign wr_byte = w_data_r[7:0];
	assign aw_got_nxt = do_wr ? 1'b0
		: (aw_got_r | (awready_r & AXI_REQ_I.awvalid));
	assign w_got_nxt = do_wr ? 1'b0
		: (w_got_r | (wready_r & AXI_REQ_I.wvalid));
	assign bvalid_nxt = (bvalid_r & ~AXI_REQ_I.bready) | do_wr;
	assign rvalid_nxt = (rvalid_r & ~AXI_REQ_I.rready)
		| (arready_r & AXI_REQ_I.arvalid);

	always_comb
	begin
		case (aw_addr_r)
			RCMR_MIRROR_SEL_ADDR, RCMR_CLEAR_ADDR, RCMR_KEY_FIRST_ADDR,
			RCMR_CFG_ADDR, RCMR_KEY_SECOND_ADDR, RCMR_CTRL_ADDR,
			RCMR_IRQ_STAT_ADDR, RCMR_IRQ_MASK_ADDR: wr_hit = 1'b1;
			RCMR_FLAGS_ADDR: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= 32'h00000000;
			w_data_r <= 32'h00000000;
			w_lane0_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RCMR_RESP_OKAY;
		end
		else
		begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awready_r <= ~aw_got_nxt & ~bvalid_nxt;
			wready_r <= ~w_got_nxt & ~bvalid_nxt;
			bvalid_r <= bvalid_nxt;
			if (awready_r && AXI_REQ_I.awvalid)
				aw_addr_r <= AXI_REQ_I.awaddr;
			if (wready_r && AXI_REQ_I.wvalid)
			begin
				w_data_r <= AXI_REQ_I.wdata;
				w_lane0_r <= AXI_REQ_I.wstrb[0];
			end
			if (do_wr)
				bresp_r <= wr_hit ? RCMR_RESP_OKAY : RCMR_RESP_DECERR;
		end
	end

	// Only byte lane 0 carries register bits
	logic wr_en;
	assign wr_en = do_wr & w_lane0_r;

	// ****************************************************
	// Boot sequencer and reset generation
	// ****************************************************
	rcmr_state_t state_r;
	rcmr_state_t state_nxt;
	logic [15:0] cnt_r;
	logic soft_cause_r;
	logic sw_req_r;
	logic ext_low;
	logic ext_fall;
	logic trig;
	logic soft_trig;
	logic [7:0] cfg_r;

	assign ext_low = ~ext_s2_r;
	assign ext_fall = ext_prev_r & ~ext_s2_r;
	assign soft_trig = WDT_EXPIRE_I | sw_req_r;
	assign trig = ext_low | soft_trig;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			RCMR_ST_HOLD:
				if (!trig && cnt_r == 16'h0000)
					state_nxt = RCMR_ST_KERNEL;
			RCMR_ST_KERNEL:
				if (trig)
					state_nxt = RCMR_ST_HOLD;
				else if (cnt_r == 16'h0000)
					state_nxt = boot_s2_r ? RCMR_ST_USER
						: RCMR_ST_DOWNLOAD;
			RCMR_ST_USER, RCMR_ST_DOWNLOAD:
				if (trig)
					state_nxt = RCMR_ST_HOLD;
			default: state_nxt = RCMR_ST_HOLD;
		endcase
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			state_r <= RCMR_ST_HOLD;
			cnt_r <= RCMR_RST_HOLD_CYC;
			soft_cause_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (trig)
				cnt_r <= RCMR_RST_HOLD_CYC;
			else if (state_r != state_nxt)
				cnt_r <= RCMR_KERNEL_CYC;
			else if (cnt_r != 16'h0000)
				cnt_r <= cnt_r - 16'h0001;
			// External reset overrides retention for the whole hold
			if (ext_low)
				soft_cause_r <= 1'b0;
			else if (soft_trig && state_r != RCMR_ST_HOLD)
				soft_cause_r <= 1'b1;
		end
	end

	// Domain resets; retention only spares a watchdog or software reset
	logic hold_nxt;
	logic soft_nxt;
	assign hold_nxt = (state_nxt == RCMR_ST_HOLD);
	assign soft_nxt = ~ext_low
		& (soft_cause_r | (soft_trig & state_r != RCMR_ST_HOLD));

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			SYS_RST_N_O <= 1'b0;
			GPIO_RST_N_O <= 1'b0;
			DAC_RST_N_O <= 1'b0;
			KERNEL_RUN_O <= 1'b0;
			USER_RUN_O <= 1'b0;
			DOWNLOAD_MODE_O <= 1'b0;
		end
		else
		begin
			SYS_RST_N_O <= ~hold_nxt;
			GPIO_RST_N_O <= ~hold_nxt
				| (soft_nxt & cfg_r[RCMR_CFG_GPIO]);
			DAC_RST_N_O <= ~hold_nxt
				| (soft_nxt & cfg_r[RCMR_CFG_DAC]);
			KERNEL_RUN_O <= (state_nxt == RCMR_ST_KERNEL);
			USER_RUN_O <= (state_nxt == RCMR_ST_USER);
			DOWNLOAD_MODE_O <= (state_nxt == RCMR_ST_DOWNLOAD);
		end
	end

	// ****************************************************
	// Low memory mirror
	// ****************************************************
	logic mirror_r;

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
			mirror_r <= RCMR_MIRROR_RST[RCMR_MIRROR_BIT];
		else if (trig)
			mirror_r <= 1'b0;
		else if (wr_en && aw_addr_r == RCMR_MIRROR_SEL_ADDR)
			mirror_r <= wr_byte[RCMR_MIRROR_BIT];
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
			FETCH_SRAM_O <= 1'b0;
		else
			FETCH_SRAM_O <= mirror_r & ~trig
				& (FETCH_ADDR_I >= RCMR_MIRROR_BASE)
				& (FETCH_ADDR_I <= RCMR_MIRROR_TOP);
	end

	// ****************************************************
	// Reset cause flags and software reset request
	// ****************************************************
	logic [2:0] flags_r;
	logic clr_wr;
	assign clr_wr = wr_en & (aw_addr_r == RCMR_CLEAR_ADDR);

	// A cause arriving with a clear write survives the clear
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
			flags_r <= RCMR_FLAGS_RST[2:0];
		else
		begin
			flags_r <= (flags_r & ~(clr_wr ? wr_byte[2:0]
				: 3'h0))
				| {sw_req_r, WDT_EXPIRE_I, 1'b0};
		end
	end

	// Request lasts one cycle; the sequencer holds the reset itself
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
			sw_req_r <= 1'b0;
		else
			sw_req_r <= wr_en & (aw_addr_r == RCMR_CTRL_ADDR)
				& wr_byte[RCMR_CTRL_SWRST];
	end

	// ****************************************************
	// Keyed retention configuration
	// ****************************************************
	rcmr_key_t key_r;
	logic [7:0] cfg_pend_r;
	logic key_err;
	logic key1_hit;
	logic cfg_hit;
	logic key2_hit;

	assign key1_hit = (aw_addr_r == RCMR_KEY_FIRST_ADDR)
		& (wr_byte == RCMR_KEY_FIRST);
	assign cfg_hit = (aw_addr_r == RCMR_CFG_ADDR);
	assign key2_hit = (aw_addr_r == RCMR_KEY_SECOND_ADDR)
		& (wr_byte == RCMR_KEY_SECOND);
	// Any other write inside a started sequence is a key error; a first key write rearms it, others abort it
	assign key_err = wr_en & (key_r != RCMR_KEY_IDLE)
		& ~((key_r == RCMR_KEY_ARMED) & cfg_hit)
		& ~((key_r == RCMR_KEY_LOADED) & key2_hit);

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			key_r <= RCMR_KEY_IDLE;
			cfg_pend_r <= RCMR_CFG_RST;
			cfg_r <= RCMR_CFG_RST;
		end
		else if (wr_en)
		begin
			case (key_r)
				RCMR_KEY_IDLE:
					key_r <= key1_hit ? RCMR_KEY_ARMED : RCMR_KEY_IDLE;
				RCMR_KEY_ARMED:
					if (cfg_hit)
					begin
						key_r <= RCMR_KEY_LOADED;
						cfg_pend_r <= wr_byte & RCMR_CFG_MASK;
					end
					else
						key_r <= key1_hit ? RCMR_KEY_ARMED
							: RCMR_KEY_IDLE;
				RCMR_KEY_LOADED:
				begin
					if (key2_hit)
						cfg_r <= cfg_pend_r;
					key_r <= (!key2_hit && key1_hit) ? RCMR_KEY_ARMED
						: RCMR_KEY_IDLE;
				end
				default: key_r <= RCMR_KEY_IDLE;
			endcase
		end
	end

	// ****************************************************
	// Interrupt status and mask
	// ****************************************************
	logic [RCMR_IRQ_W-1:0] irq_stat_r;
	logic [RCMR_IRQ_W-1:0] irq_mask_r;
	logic [RCMR_IRQ_W-1:0] irq_evt;
	logic [RCMR_IRQ_W-1:0] irq_clr;

	assign irq_evt = {key_err, sw_req_r, WDT_EXPIRE_I, ext_fall};
	assign irq_clr = (wr_en && aw_addr_r == RCMR_IRQ_STAT_ADDR)
		? wr_byte[RCMR_IRQ_W-1:0] : {RCMR_IRQ_W{1'b0}};

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			irq_stat_r <= {RCMR_IRQ_W{1'b0}};
			irq_mask_r <= {RCMR_IRQ_W{1'b0}};
			IRQ_O <= 1'b0;
		end
		else
		begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
			if (wr_en && aw_addr_r == RCMR_IRQ_MASK_ADDR)
				irq_mask_r <= wr_byte[RCMR_IRQ_W-1:0];
			IRQ_O <= |(((irq_stat_r & ~irq_clr) | irq_evt) & irq_mask_r);
		end
	end

	// ****************************************************
	// Read path
	// ****************************************************
	always_comb
	begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		case (AXI_REQ_I.araddr)
			RCMR_MIRROR_SEL_ADDR: rd_word[0] = mirror_r;
			// All zero reads as an external reset
			RCMR_FLAGS_ADDR: rd_word[2:0] = flags_r;
			RCMR_CFG_ADDR: rd_word[7:0] = cfg_r;
			RCMR_IRQ_STAT_ADDR: rd_word[RCMR_IRQ_W-1:0] = irq_stat_r;
			RCMR_IRQ_MASK_ADDR: rd_word[RCMR_IRQ_W-1:0] = irq_mask_r;
			RCMR_CLEAR_ADDR, RCMR_KEY_FIRST_ADDR, RCMR_KEY_SECOND_ADDR,
			RCMR_CTRL_ADDR: rd_word = 32'h00000000;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RCMR_RESP_OKAY;
		end
		else
		begin
			arready_r <= ~rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (arready_r && AXI_REQ_I.arvalid)
			begin
				rdata_r <= rd_word;
				rresp_r <= rd_hit ? RCMR_RESP_OKAY : RCMR_RESP_DECERR;
			end
		end
	end

	assign AXI_RSP_O.awready = awready_r;
	assign AXI_RSP_O.wready = wready_r;
	assign AXI_RSP_O.bresp = bresp_r;
	assign AXI_RSP_O.bvalid = bvalid_r;
	assign AXI_RSP_O.arready = arready_r;
	assign AXI_RSP_O.rdata = rdata_r;
	assign AXI_RSP_O.rresp = rresp_r;
	assign AXI_RSP_O.rvalid = rvalid_r;
endmodule : rcmr_top
